/* ssrx_fifo.sv */
// Parameterised valid/ready FIFO held in flip-flops.
`timescale 1ns/1ps
module ssrx_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input  wire logic             aclk,     // System clock.
   input  wire logic             clear,    // Synchronous flush.
   input  wire logic [WIDTH-1:0] in_data,  // Write data.
   input  wire logic             in_valid, // Write request.
   output logic                  in_ready, // Space available.
   output logic [WIDTH-1:0]      out_data, // Oldest word.
   output logic                  out_valid,// Word available.
   input  wire logic             out_ready // Pop request.
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge aclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (clear) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

/* ssrx_master.sv */
// Behavioural clocked-serial master that shifts words into the receiver.
`timescale 1ns/1ps
module ssrx_master (
   output logic sclk,  // Shift clock to the receiver.
   output logic sdata  // Serial data to the receiver.
);
   logic idle_lvl;
   initial begin
      idle_lvl = 1'b0;
      sclk = 1'b0;
      sdata = 1'b0;
   end
   // Sets the level at which the shift clock rests between frames.
   task automatic set_idle(input logic lvl);
      #1.3;
      idle_lvl = lvl;
      sclk = lvl;
   endtask
   task automatic send(input logic [8:0] w, input logic nine);
      int i;
      // An odd offset keeps the link edges out of phase with the system clock.
      #1.3;
      for (i = 0; i < (nine ? 9 : 8); i++) begin
         sdata = w[i];
         #32 sclk = ~idle_lvl;
         #32 sclk = idle_lvl;
      end
      // The clock rests at idle_lvl between frames; data no longer holds the last bit.
      #5 sdata = ~sdata;
   endtask
endmodule

/* ssrx_pkg.sv */
// Package with register map, field positions and carrier types for the clocked-slave receiver.
package ssrx_pkg;
   localparam logic [7:0] OFF_RX_STATUS   = 8'h00;
   localparam logic [7:0] OFF_RX_BUFFER   = 8'h04;
   localparam logic [7:0] OFF_TX_STATUS   = 8'h08;
   localparam logic [7:0] OFF_BAUD_CTRL   = 8'h0C;
   localparam logic [7:0] OFF_BAUD_LOW    = 8'h10;
   localparam logic [7:0] OFF_BAUD_HIGH   = 8'h14;
   localparam logic [7:0] OFF_INT_CTRL    = 8'h18;
   localparam logic [7:0] OFF_INT_STATUS  = 8'h1C;
   // Receive status/control fields.
   localparam int RS_PORT_EN   = 7;
   localparam int RS_NINE_EN   = 6;
   localparam int RS_SINGLE_EN = 5;
   localparam int RS_CONT_EN   = 4;
   localparam int RS_OVERRUN   = 1;
   localparam int RS_NINTH     = 0;
   // Transmit status/control fields.
   localparam int TS_CLK_MASTER = 7;
   localparam int TS_SYNC       = 4;
   localparam int TS_SHIFT_IDLE = 1;
   // Baud control fields.
   localparam int BC_RX_IDLE   = 6;
   localparam int BC_CLK_POL   = 4;
   // Interrupt control fields.
   localparam int IC_GLOBAL    = 7;
   localparam int IC_PERIPH    = 6;
   localparam int IC_RX_EN     = 5;
   localparam int IC_SLEEP     = 0;
   // Interrupt status fields.
   localparam int IS_RX_FLAG   = 0;
   localparam int IS_WAKE      = 1;
   localparam int IS_VECTOR    = 2;
   localparam logic [7:0] RESET_BYTE   = 8'h00;
   localparam logic [7:0] RESET_TXSTAT = 8'h02;
   localparam int FIFO_DEPTH   = 16;
   // Bit counter value at the last bit of an eight-bit and a nine-bit word.
   localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
   localparam logic [3:0] LAST_BIT_NINE  = 4'h8;
   localparam int WORD_W       = 9;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic       ninth;
      logic [7:0] data;
   } ssrx_word_s;
endpackage

/* ssrx_top.sv */
// Clocked-slave serial receiver with AXI4-Lite register access.
// Functional notes
// - Continuous receive enable keeps the receiver armed; never idle while slave.
// - Single receive enable has no effect in clocked slave mode.
// - Reception continues while the core sleeps if continuous enable was set.
// - A complete word moves from shift register into the receive buffer FIFO.
// - Receive interrupt enable lets a completed word wake the sleeping core.
// - With global enable also set, wake branches to the interrupt vector.
// - Nine-bit enable makes each word capture a ninth bit.
// - Receive flag sets on a complete word; interrupt if receive enable set.
// - In nine-bit mode the ninth bit shows in the receive status register.
// - Reading the receive buffer returns the low eight bits of oldest word.
// - Clearing continuous or port enable clears overrun; port enable resets port.
// - Slave when clock-master select clear; port works only while enabled.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module ssrx_top
   import ssrx_pkg::*;
(
   input  wire logic        aclk,          // 250 MHz system clock.
   input  wire logic        aresetn,       // Synchronous reset, active low.
   input  wire logic [7:0]  s_axi_awaddr,  // Write address.
   input  wire logic        s_axi_awvalid, // Write address valid.
   output logic             s_axi_awready, // Write address ready.
   input  wire logic [31:0] s_axi_wdata,   // Write data.
   input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes.
   input  wire logic        s_axi_wvalid,  // Write data valid.
   output logic             s_axi_wready,  // Write data ready.
   output logic [1:0]       s_axi_bresp,   // Write response.
   output logic             s_axi_bvalid,  // Write response valid.
   input  wire logic        s_axi_bready,  // Write response ready.
   input  wire logic [7:0]  s_axi_araddr,  // Read address.
   input  wire logic        s_axi_arvalid, // Read address valid.
   output logic             s_axi_arready, // Read address ready.
   output logic [31:0]      s_axi_rdata,   // Read data.
   output logic [1:0]       s_axi_rresp,   // Read response.
   output logic             s_axi_rvalid,  // Read valid.
   input  wire logic        s_axi_rready,  // Read response ready.
   input  wire logic        serial_clock_in,  // Clock pin level from the master.
   output logic             serial_clock_out, // Clock pin drive value.
   output logic             serial_clock_oe,  // Clock pin drive enable.
   input  wire logic        serial_data_in,   // Data pin level from the master.
   output logic             serial_data_out,  // Data pin drive value.
   output logic             serial_data_oe,   // Data pin drive enable.
   output logic             wake_request,     // Wake pulse to the sleeping core.
   output logic             vector_request    // Interrupt vector request pulse.
);
   logic [7:0] receive_status_control;
   logic [7:0] transmit_status_control;
   logic [7:0] baud_control;
   logic [7:0] baud_divisor_low;
   logic [7:0] baud_divisor_high;
   logic [7:0] int_control;
   logic       receive_interrupt_flag;
   logic       overrun_error;
   logic       ninth_receive_bit;
   logic [2:0] clk_sync;
   logic [1:0] dat_sync;
   logic [8:0] receive_shift_register;
   logic [3:0] bit_count;
   logic       port_on;
   logic       rx_active;
   logic       shift_edge;
   logic       word_done;
   ssrx_word_s word_in;
   ssrx_word_s word_out;
   logic       fifo_in_ready;
   logic       fifo_out_valid;
   logic       fifo_pop;
   logic       fifo_clear;
   logic       aw_held;
   logic       w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic       wr_go;
   logic       rd_go;
   logic [31:0] next_rdata;
   logic       next_rd_ok;

   function automatic logic wr_hit(input logic [7:0] off);
      wr_hit = wr_go && (aw_addr == off) && w_strb[0];
   endfunction

   // Slave mode needs sync set, master clock clear and port enabled.
   // slave mode gating
   assign port_on   = receive_status_control[RS_PORT_EN] && transmit_status_control[TS_SYNC]
                      && !transmit_status_control[TS_CLK_MASTER];
   assign rx_active = port_on && receive_status_control[RS_CONT_EN];
   assign fifo_clear = !aresetn || !receive_status_control[RS_PORT_EN];

   // Two flops per pin, the third clock flop only feeds the edge detector.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_sync <= 3'h0;
         dat_sync <= 2'h0;
      end else begin
         clk_sync <= {clk_sync[1:0], serial_clock_in};
         dat_sync <= {dat_sync[0], serial_data_in};
      end
   end

   assign shift_edge = (clk_sync[2] != clk_sync[1])
                       && (clk_sync[1] == !baud_control[BC_CLK_POL]);

   assign word_done = rx_active && shift_edge
                      && (bit_count == (receive_status_control[RS_NINE_EN]
                                        ? LAST_BIT_NINE : LAST_BIT_EIGHT));

   always_ff @(posedge aclk) begin
      if (!aresetn || !rx_active) begin
         bit_count              <= 4'h0;
         receive_shift_register <= 9'h000;
      end else if (shift_edge) begin
         // Bits arrive least significant first.
         receive_shift_register <= {dat_sync[1], receive_shift_register[8:1]};
         bit_count <= word_done ? 4'h0 : bit_count + 4'h1;
      end
   end

   always_comb begin
      word_in = '0;
      if (receive_status_control[RS_NINE_EN]) begin
         word_in = ssrx_word_s'({dat_sync[1], receive_shift_register[8:1]});
      end else begin
         word_in.data = {dat_sync[1], receive_shift_register[8:2]};
      end
   end

   ssrx_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .aclk      (aclk),
      .clear     (fifo_clear),
      .in_data   (word_in),
      .in_valid  (word_done),
      .in_ready  (fifo_in_ready),
      .out_data  (word_out),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop)
   );

   assign fifo_pop = rd_go && (s_axi_araddr == OFF_RX_BUFFER);

   // Overrun when a word completes with the FIFO full; the set wins.
   // overrun cleared by enables
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overrun_error <= 1'b0;
      end else if (word_done && !fifo_in_ready) begin
         overrun_error <= 1'b1;
      end else if (!rx_active) begin
         overrun_error <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         receive_interrupt_flag <= 1'b0;
         ninth_receive_bit      <= 1'b0;
      end else begin
         receive_interrupt_flag <= fifo_out_valid && !fifo_pop;
         // An empty buffer shows zero rather than stale storage.
         ninth_receive_bit      <= fifo_out_valid && word_out.ninth;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_request   <= 1'b0;
         vector_request <= 1'b0;
      end else begin
         wake_request   <= word_done && fifo_in_ready && int_control[IC_RX_EN]
                           && int_control[IC_PERIPH] && int_control[IC_SLEEP];
         vector_request <= word_done && fifo_in_ready && int_control[IC_RX_EN]
                           && int_control[IC_PERIPH] && int_control[IC_GLOBAL];
      end
   end

   // Pins are receive only; drivers held off.
   always_ff @(posedge aclk) begin
      serial_clock_out <= 1'b0;
      serial_clock_oe  <= 1'b0;
      serial_data_out  <= 1'b0;
      serial_data_oe   <= 1'b0;
   end

   // Write channel: address and data taken in either order.
   assign wr_go = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[1:0] == 2'h0 && aw_addr <= OFF_INT_CTRL
                             && aw_addr != OFF_RX_BUFFER) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   // Control registers; a port disable flushes the buffer and idles the receiver.
   // port disable resets port
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         receive_status_control  <= RESET_BYTE;
         transmit_status_control <= RESET_TXSTAT;
         baud_control            <= RESET_BYTE;
         baud_divisor_low        <= RESET_BYTE;
         baud_divisor_high       <= RESET_BYTE;
         int_control             <= RESET_BYTE;
      end else begin
         if (wr_hit(OFF_RX_STATUS)) begin
            receive_status_control <= {w_data[7:4], 4'h0};
         end
         if (wr_hit(OFF_TX_STATUS)) begin
            transmit_status_control <= {w_data[7:2], 1'b1, w_data[0]};
         end
         if (wr_hit(OFF_BAUD_CTRL)) begin
            baud_control <= {2'h0, w_data[5:0]};
         end
         if (wr_hit(OFF_BAUD_LOW)) begin
            baud_divisor_low <= w_data[7:0];
         end
         if (wr_hit(OFF_BAUD_HIGH)) begin
            baud_divisor_high <= w_data[7:0];
         end
         if (wr_hit(OFF_INT_CTRL)) begin
            int_control <= w_data[7:0];
         end
      end
   end

   // Read channel: one-cycle answer after the address is taken.
   assign rd_go = s_axi_arvalid && s_axi_arready;

   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rd_ok = 1'b1;
      unique case (s_axi_araddr)
         OFF_RX_STATUS:  next_rdata[7:0] = {receive_status_control[7:4], 2'h0,
                                            overrun_error, ninth_receive_bit};
         OFF_RX_BUFFER:  next_rdata[7:0] = fifo_out_valid ? word_out.data : 8'h00;
         OFF_TX_STATUS:  next_rdata[7:0] = transmit_status_control;
         OFF_BAUD_CTRL:  next_rdata[7:0] = {1'b0, !rx_active, baud_control[5:0]};
         OFF_BAUD_LOW:   next_rdata[7:0] = baud_divisor_low;
         OFF_BAUD_HIGH:  next_rdata[7:0] = baud_divisor_high;
         OFF_INT_CTRL:   next_rdata[7:0] = int_control;
         OFF_INT_STATUS: next_rdata[7:0] = {5'h00, vector_request, wake_request,
                                            receive_interrupt_flag};
         default:        next_rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !rd_go;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   flag_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
      fifo_out_valid && !fifo_pop |=> receive_interrupt_flag)
      else $error("receive flag not set while a word waits");
   overrun_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !rx_active && !word_done |=> !overrun_error)
      else $error("overrun survived receiver disable");
   wake_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wake_request |-> $past(word_done) && $past(int_control[IC_RX_EN]))
      else $error("wake without a received word");
   vector_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      vector_request |-> $past(int_control[IC_GLOBAL]))
      else $error("vector without global enable");
   idle_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !rx_active |=> bit_count == 4'h0)
      else $error("bit counter moved while receiver off");
   word_push_a: assert property (@(posedge aclk) disable iff (!aresetn)
      word_done && fifo_in_ready |=> fifo_out_valid)
      else $error("completed word not buffered");
   master_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
      transmit_status_control[TS_CLK_MASTER] |-> !word_done)
      else $error("receiving while clock master");
   pins_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 (!serial_clock_oe && !serial_data_oe))
      else $error("pin driver enabled");
   flag_land_a: assert property (@(posedge aclk) disable iff (!aresetn)
      word_done && fifo_in_ready ##1 !fifo_pop |=> receive_interrupt_flag)
      else $error("pushed word did not raise the receive flag");
   ninth_show_a: assert property (@(posedge aclk) disable iff (!aresetn)
      word_done && fifo_in_ready && !fifo_out_valid && receive_status_control[RS_NINE_EN]
      |=> ##1 ninth_receive_bit == $past(dat_sync[1], 2))
      else $error("ninth bit of oldest word not shown");
   overrun_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      word_done && !fifo_in_ready |=> overrun_error)
      else $error("overrun not raised on a full buffer");
   shift_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rx_active && shift_edge && !word_done |=> bit_count == $past(bit_count) + 4'h1)
      else $error("bit counter did not advance on a clock edge");
   read_pop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_go && (s_axi_araddr == OFF_RX_BUFFER) && fifo_out_valid
      |=> s_axi_rdata == {24'h000000, $past(word_out.data)})
      else $error("buffer read did not return the oldest word");
   single_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !receive_status_control[RS_CONT_EN] |-> !word_done)
      else $error("word received without continuous enable");
   wake_fire_a: assert property (@(posedge aclk) disable iff (!aresetn)
      word_done && fifo_in_ready && int_control[IC_RX_EN] && int_control[IC_PERIPH]
      && int_control[IC_SLEEP] |=> wake_request)
      else $error("enabled word did not wake the core");
endmodule

/* testbench.sv */
// Self-checking bench for the clocked-slave receiver over AXI4-Lite.
`timescale 1ns/1ps
module testbench;
   import ssrx_pkg::*;
   logic        aclk, aresetn;
   logic [7:0]  aw_addr, ar_addr;
   logic [31:0] w_data, r_data;
   logic [3:0]  w_strb;
   logic        aw_valid, w_valid, b_ready, ar_valid, r_ready;
   logic        aw_ready, w_ready, b_valid, ar_ready, r_valid;
   logic [1:0]  b_resp, r_resp;
   logic        ser_clk, ser_dat, ck_out, ck_oe, dt_out, dt_oe, wake, vec;
   logic [31:0] d;
   logic [1:0]  r;
   int          n_fail, num_checks, n_wake, n_vec, n_oe, i;
   ssrx_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_addr),
      .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready), .s_axi_wdata(w_data),
      .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready),
      .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
      .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
      .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
      .s_axi_rready(r_ready), .serial_clock_in(ser_clk), .serial_clock_out(ck_out),
      .serial_clock_oe(ck_oe), .serial_data_in(ser_dat), .serial_data_out(dt_out),
      .serial_data_oe(dt_oe), .wake_request(wake), .vector_request(vec));
   ssrx_master mst (.sclk(ser_clk), .sdata(ser_dat));
   always #2 aclk = ~aclk;
   always @(posedge aclk) begin
      if (aresetn === 1'b1) begin
         if (wake === 1'b1) n_wake++;
         if (vec === 1'b1) n_vec++;
         if (ck_oe !== 1'b0 || dt_oe !== 1'b0) n_oe++;
      end
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] t=%0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
      int n;
      logic done;
      @(posedge aclk);
      aw_addr <= a;
      w_data <= {24'h000000, v};
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      n = 0;
      done = 1'b0;
      while (!done) begin
         @(posedge aclk);
         n++;
         if (aw_valid && aw_ready) aw_valid <= 1'b0;
         if (w_valid && w_ready) w_valid <= 1'b0;
         if (b_valid === 1'b1) begin
            done = 1'b1;
            b_ready <= 1'b0;
            chk({30'h0, b_resp}, {30'h0, er});
         end else if (n > 100) begin
            n_fail++;
            print_verdict();
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
      int n;
      logic done;
      @(posedge aclk);
      ar_addr <= a;
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      n = 0;
      done = 1'b0;
      while (!done) begin
         @(posedge aclk);
         n++;
         if (ar_valid && ar_ready) ar_valid <= 1'b0;
         if (r_valid === 1'b1) begin
            done = 1'b1;
            dv = r_data;
            rv = r_resp;
            r_ready <= 1'b0;
         end else if (n > 100) begin
            n_fail++;
            print_verdict();
         end
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a, d, r);
      chk(d, e);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
   endtask
   task automatic flag_is(input logic e);
      rd(OFF_INT_STATUS, d, r);
      chk({31'h0, d[IS_RX_FLAG]}, {31'h0, e});
   endtask
   // Polls the receive flag; a word should land a few cycles after the last active clock edge of the frame.
   task automatic wflag;
      int n;
      n = 0;
      do begin
         rd(OFF_INT_STATUS, d, r);
         n++;
      end while (d[IS_RX_FLAG] !== 1'b1 && n < 30);
      chk({31'h0, d[IS_RX_FLAG]}, 32'h1);
   endtask
   task automatic tdone(input string s);
      $display("test %s done, mismatches so far %0d", s, n_fail);
   endtask
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {aw_addr, ar_addr, w_data} = '0;
      w_strb = 4'hF;
      {aw_valid, w_valid, b_ready, ar_valid, r_ready} = '0;
      {n_fail, num_checks, n_wake, n_vec, n_oe} = '0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rchk(OFF_RX_STATUS, {24'h0, RESET_BYTE});
      rchk(OFF_TX_STATUS, {24'h0, RESET_TXSTAT});
      rchk(OFF_INT_CTRL, {24'h0, RESET_BYTE});
      wr(OFF_BAUD_LOW, 8'hA5, RESP_OKAY);
      rchk(OFF_BAUD_LOW, 32'h000000A5);
      wr(OFF_BAUD_HIGH, 8'h3C, RESP_OKAY);
      rchk(OFF_BAUD_HIGH, 32'h0000003C);
      wr(OFF_RX_BUFFER, 8'h11, RESP_SLVERR);
      rd(8'h20, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      rd(8'h02, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      tdone("registers");
      wr(OFF_TX_STATUS, 8'h10, RESP_OKAY);
      wr(OFF_INT_CTRL, 8'hE0, RESP_OKAY);
      wr(OFF_RX_STATUS, 8'h90, RESP_OKAY);
      rd(OFF_BAUD_CTRL, d, r);
      chk({31'h0, d[BC_RX_IDLE]}, 32'h0);
      mst.send(9'h0A5, 1'b0);
      wflag();
      chk(32'(n_vec), 32'h1);
      chk(32'(n_wake), 32'h0);
      rchk(OFF_RX_BUFFER, 32'h000000A5);
      flag_is(1'b0);
      tdone("receive");
      wr(OFF_INT_CTRL, 8'h61, RESP_OKAY);
      mst.send(9'h03C, 1'b0);
      wflag();
      chk(32'(n_wake), 32'h1);
      chk(32'(n_vec), 32'h1);
      rchk(OFF_RX_BUFFER, 32'h0000003C);
      tdone("sleep");
      wr(OFF_INT_CTRL, 8'h00, RESP_OKAY);
      wr(OFF_RX_STATUS, 8'hB0, RESP_OKAY);
      mst.send(9'h0C3, 1'b0);
      wflag();
      rchk(OFF_RX_BUFFER, 32'h000000C3);
      chk(32'(n_wake), 32'h1);
      tdone("single enable");
      wr(OFF_RX_STATUS, 8'hD0, RESP_OKAY);
      for (i = 0; i < 2; i++) begin
         mst.send(i ? 9'h0A5 : 9'h15A, 1'b1);
         wflag();
         rchk(OFF_RX_STATUS, i ? 32'hD0 : 32'hD1);
         rchk(OFF_RX_BUFFER, i ? 32'hA5 : 32'h5A);
      end
      tdone("nine bit");
      wr(OFF_RX_STATUS, 8'h90, RESP_OKAY);
      // The seventeenth word finds the buffer full and is dropped.
      for (i = 0; i < 17; i++) mst.send(9'(8'h30 + i), 1'b0);
      rchk(OFF_RX_STATUS, 32'h00000092);
      for (i = 0; i < 16; i++) rchk(OFF_RX_BUFFER, 32'(8'h30 + i));
      flag_is(1'b0);
      rchk(OFF_RX_STATUS, 32'h00000092);
      wr(OFF_RX_STATUS, 8'h80, RESP_OKAY);
      rchk(OFF_RX_STATUS, 32'h00000080);
      tdone("overrun");
      for (i = 0; i < 3; i++) begin
         wr(OFF_TX_STATUS, i == 0 ? 8'h90 : (i == 1 ? 8'h00 : 8'h10), RESP_OKAY);
         wr(OFF_RX_STATUS, i == 2 ? 8'h10 : 8'h90, RESP_OKAY);
         mst.send(9'h077, 1'b0);
         repeat (40) @(posedge aclk);
         flag_is(1'b0);
      end
      chk(32'(n_oe), 32'h0);
      tdone("refused");
      // Clock resting high, data taken on the falling edge; receiver is off while it moves.
      mst.set_idle(1'b1);
      wr(OFF_BAUD_CTRL, 8'h10, RESP_OKAY);
      wr(OFF_RX_STATUS, 8'h90, RESP_OKAY);
      rchk(OFF_BAUD_CTRL, 32'h00000010);
      mst.send(9'h096, 1'b0);
      wflag();
      rchk(OFF_RX_BUFFER, 32'h00000096);
      tdone("polarity");
      print_verdict();
   end
endmodule
